/* File: pkg/epdb_defs.vh */
// Constants for the event polarity, bank select and debounce block.
// Assumes an 8-bit host port with a 3-bit port address and a 125 MHz clock.
`ifndef EPDB_DEFS_VH
`define EPDB_DEFS_VH

// ----------------------------------------
// Port addresses
// ----------------------------------------
`define EPDB_PORT_FILTER_EN 3'h0
`define EPDB_PORT_LEN_LOW 3'h1
`define EPDB_PORT_LEN_HIGH 3'h2
`define EPDB_PORT_CLK_SRC 3'h3
`define EPDB_PORT_SUMMARY 3'h6
`define EPDB_PORT_BANK 3'h7
`define EPDB_LAST_DATA_PORT 3'h5

// ----------------------------------------
// Banks and fields
// ----------------------------------------
`define EPDB_BANK_IO 2'h0
`define EPDB_BANK_EVENT 2'h1
`define EPDB_BANK_FILTER 2'h2
`define EPDB_BANK_MSB 7
`define EPDB_BANK_LSB 6
`define EPDB_POL_HIGH_W 4
`define EPDB_LEN_HIGH_W 4
`define EPDB_SUMMARY_ANY 7
`define EPDB_CLK_SRC_BIT 0
`define EPDB_LAST_LINE 47

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EPDB_RST_BYTE 8'h00
`define EPDB_RST_POL_LOW 8'h00
`define EPDB_RST_POL_HIGH 4'h0
`define EPDB_RST_FILTER_EN 6'h00
`define EPDB_RST_LEN 12'h000
`define EPDB_RST_LINES 48'h0000_0000_0000
`define EPDB_RST_BANK 2'h0

// ----------------------------------------
// Enhanced mode unlock sequence
// ----------------------------------------
`define EPDB_KEY0 8'h07
`define EPDB_KEY1 8'h0D
`define EPDB_KEY2 8'h06
`define EPDB_KEY3 8'h12
`define EPDB_KEY_LAST 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
// Last count of the divide by 15 that makes the internal tick from 125 MHz
`define EPDB_TICK_LAST 4'hE
// Nominal lengths of 4 us, 64 us, 1 ms and 8 ms counted in 8 MHz ticks
`define EPDB_DUR0_TICKS 16'h0020
`define EPDB_DUR1_TICKS 16'h0200
`define EPDB_DUR2_TICKS 16'h1F40
`define EPDB_DUR3_TICKS 16'hFA00

`endif

/* File: rtl/epdb_filter.v */
// Debounce filter for one 8-line port.
// Assumes tick is a one-cycle enable at the debounce clock rate.
`default_nettype none
`include "epdb_defs.vh"

module epdb_filter (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  input wire clear,
  // Timing
  input wire tick,
  input wire [15:0] dur_ticks,
  // Lines
  input wire [7:0] raw,
  output reg [7:0] level
);

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_line
      reg [15:0] cnt;
      // A level passes only after it has stood for the full count; any return resets
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          cnt <= 16'h0000;
          level[i] <= 1'b0;
        end else if (clear || raw[i] == level[i]) begin
          cnt <= 16'h0000;
          if (clear) begin
            level[i] <= 1'b0;
          end
        end else if (tick) begin
          if (cnt + 16'h0001 >= dur_ticks) begin
            level[i] <= raw[i];
            cnt <= 16'h0000;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* File: rtl/epdb_top.v */
// Enhanced-mode event polarity, bank select and debounce for 48 field lines.
// Assumes a synchronous 8-bit port bus and field inputs synchronous to clk.
// Overview of operation
// - Bank1 port7 bits 0-3 set ports 4-5 polarity
// - Polarity zero falling edge, one rising edge
// - Bank1 port6 bit n sets nibble n polarity
// - No event until line sense enabled
// - No interrupt request without interrupt enable
// - Port7 bits 7:6 written select active bank
// - Bank1 port7 read returns bank bits 7:6
// - Bank2 port7 reads and writes bank select
// - Bank2 port0 holds per-port debounce enables
// - Debounce filters readback and events, enhanced only
// - Duration codes two bits per port
// - Codes give 4us 64us 1ms 8ms
// - Duration codes reset to 00
// - Bank2 port3 bit0 picks debounce clock
// - Clock select bits 0-7 read zero
// - Four-byte unlock after reset, written with interrupt enable low, enters enhanced mode
// - Reset gives standard mode, everything disabled
// - Bank1 write 0 clears, 1 enables sensing
`default_nettype none
`include "epdb_defs.vh"

module epdb_top #(
  parameter [15:0] DUR0_TICKS = `EPDB_DUR0_TICKS,
  parameter [15:0] DUR1_TICKS = `EPDB_DUR1_TICKS,
  parameter [15:0] DUR2_TICKS = `EPDB_DUR2_TICKS,
  parameter [15:0] DUR3_TICKS = `EPDB_DUR3_TICKS
) (
  // Clock and resets
  input wire clk,
  input wire reset_n,
  input wire soft_reset,
  // Host port
  input wire [2:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  // Interrupt enable held outside this block
  input wire irq_enable,
  output reg irq_request,
  // Field lines
  input wire [47:0] field_in,
  output reg [47:0] line_level,
  // Status
  output reg enhanced,
  output reg [1:0] bank
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [15:0] dur_lookup;
    input [1:0] code;
    begin
      case (code)
        2'h0: dur_lookup = DUR0_TICKS;
        2'h1: dur_lookup = DUR1_TICKS;
        2'h2: dur_lookup = DUR2_TICKS;
        default: dur_lookup = DUR3_TICKS;
      endcase
    end
  endfunction

  function [7:0] bank_byte;
    input [1:0] b;
    begin
      bank_byte = {b, 6'h00};
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] pol_low;
  reg [3:0] pol_high;
  reg [5:0] filter_en;
  reg [11:0] len_codes;
  reg clk_src_internal;
  reg [47:0] sense_en;
  reg [47:0] flag;
  reg [47:0] prev_level;
  reg [1:0] key_idx;
  reg key_dead;
  reg [3:0] div_cnt;
  reg ext_prev;
  reg tick;

  wire wr_bank = wr_en && enhanced && addr == `EPDB_PORT_BANK;
  wire [11:0] pol_all = {pol_high, pol_low};
  wire [47:0] filtered;
  wire [47:0] eff_level;
  wire [47:0] edge_hit;
  wire [5:0] port_any;
  wire int_tick = div_cnt == `EPDB_TICK_LAST;
  wire ext_rise = field_in[`EPDB_LAST_LINE] && !ext_prev;

  reg [7:0] next_key;
  always @* begin
    case (key_idx)
      2'h0: next_key = `EPDB_KEY0;
      2'h1: next_key = `EPDB_KEY1;
      2'h2: next_key = `EPDB_KEY2;
      default: next_key = `EPDB_KEY3;
    endcase
  end

  // ----------------------------------------
  // Unlock and bank select
  // ----------------------------------------
  // Any stray access or wrong byte kills the unlock until the next reset
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enhanced <= 1'b0;
      key_idx <= 2'h0;
      key_dead <= 1'b0;
      bank <= `EPDB_RST_BANK;
    end else if (soft_reset) begin
      enhanced <= 1'b0;
      key_idx <= 2'h0;
      key_dead <= 1'b0;
      bank <= `EPDB_RST_BANK;
    end else begin
      if (!enhanced && !key_dead && (wr_en || rd_en)) begin
        if (wr_en && addr == `EPDB_PORT_BANK && wdata == next_key && !irq_enable) begin
          key_idx <= key_idx + 2'h1;
          if (key_idx == `EPDB_KEY_LAST) begin
            enhanced <= 1'b1;
          end
        end else begin
          key_dead <= 1'b1;
        end
      end
      if (wr_bank) begin
        bank <= wdata[`EPDB_BANK_MSB:`EPDB_BANK_LSB];
      end
    end
  end

  // ----------------------------------------
  // Polarity and filter configuration
  // ----------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pol_low <= `EPDB_RST_POL_LOW;
      pol_high <= `EPDB_RST_POL_HIGH;
      filter_en <= `EPDB_RST_FILTER_EN;
      len_codes <= `EPDB_RST_LEN;
      clk_src_internal <= 1'b0;
    end else if (soft_reset) begin
      pol_low <= `EPDB_RST_POL_LOW;
      pol_high <= `EPDB_RST_POL_HIGH;
      filter_en <= `EPDB_RST_FILTER_EN;
      len_codes <= `EPDB_RST_LEN;
      clk_src_internal <= 1'b0;
    end else if (wr_en && enhanced) begin
      if (bank == `EPDB_BANK_EVENT) begin
        if (addr == `EPDB_PORT_SUMMARY) begin
          pol_low <= wdata;
        end
        if (addr == `EPDB_PORT_BANK) begin
          pol_high <= wdata[`EPDB_POL_HIGH_W-1:0];
        end
      end
      if (bank == `EPDB_BANK_FILTER) begin
        case (addr)
          `EPDB_PORT_FILTER_EN: filter_en <= wdata[5:0];
          `EPDB_PORT_LEN_LOW: len_codes[7:0] <= wdata;
          `EPDB_PORT_LEN_HIGH: len_codes[11:8] <= wdata[`EPDB_LEN_HIGH_W-1:0];
          `EPDB_PORT_CLK_SRC: clk_src_internal <= wdata[`EPDB_CLK_SRC_BIT];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Debounce clock
  // ----------------------------------------
  // Integer divide rounds the internal tick fast, so periods never exceed nominal
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 4'h0;
      ext_prev <= 1'b0;
      tick <= 1'b0;
    end else begin
      div_cnt <= int_tick ? 4'h0 : div_cnt + 4'h1;
      ext_prev <= field_in[`EPDB_LAST_LINE];
      tick <= clk_src_internal ? int_tick : ext_rise;
    end
  end

  // ----------------------------------------
  // Per-port filters and edge detection
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < 6; p = p + 1) begin : g_port
      epdb_filter u_filter (
        .clk(clk),
        .reset_n(reset_n),
        .clear(soft_reset),
        .tick(tick),
        .dur_ticks(dur_lookup(len_codes[2*p+:2])),
        .raw(field_in[8*p+:8]),
        .level(filtered[8*p+:8])
      );
      assign eff_level[8*p+:8] = (enhanced && filter_en[p]) ?
        filtered[8*p+:8] : field_in[8*p+:8];
      assign port_any[p] = |flag[8*p+:8];
    end
  endgenerate

  genvar l;
  generate
    for (l = 0; l < 48; l = l + 1) begin : g_line
      wire pos = pol_all[l/4];
      // Last line is the debounce clock when the external source is chosen
      wire usable = (l != `EPDB_LAST_LINE) || clk_src_internal;
      assign edge_hit[l] = enhanced && sense_en[l] && usable &&
        (pos ? (eff_level[l] && !prev_level[l]) : (!eff_level[l] && prev_level[l]));
    end
  endgenerate

  // ----------------------------------------
  // Event sense flip-flops
  // ----------------------------------------
  wire wr_sense = wr_en && enhanced && bank == `EPDB_BANK_EVENT &&
    addr <= `EPDB_LAST_DATA_PORT;
  reg [47:0] next_flag;
  reg [47:0] next_sense_en;
  integer k;
  always @* begin
    next_flag = flag;
    next_sense_en = sense_en;
    for (k = 0; k < 6; k = k + 1) begin
      if (wr_sense && addr == k[2:0]) begin
        next_sense_en[8*k+:8] = wdata;
        next_flag[8*k+:8] = flag[8*k+:8] & wdata;
      end
    end
    next_flag = next_flag | edge_hit;
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sense_en <= `EPDB_RST_LINES;
      flag <= `EPDB_RST_LINES;
      prev_level <= `EPDB_RST_LINES;
      line_level <= `EPDB_RST_LINES;
      irq_request <= 1'b0;
    end else if (soft_reset) begin
      sense_en <= `EPDB_RST_LINES;
      flag <= `EPDB_RST_LINES;
      prev_level <= `EPDB_RST_LINES;
      line_level <= `EPDB_RST_LINES;
      irq_request <= 1'b0;
    end else begin
      sense_en <= next_sense_en;
      flag <= next_flag;
      prev_level <= eff_level;
      line_level <= eff_level;
      irq_request <= irq_enable && (|flag);
    end
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = `EPDB_RST_BYTE;
    if (!enhanced) begin
      if (addr <= `EPDB_LAST_DATA_PORT) begin
        next_rdata = field_in[8*addr+:8];
      end
    end else if (addr == `EPDB_PORT_BANK) begin
      next_rdata = bank_byte(bank);
    end else begin
      case (bank)
        `EPDB_BANK_IO: begin
          if (addr <= `EPDB_LAST_DATA_PORT) begin
            next_rdata = eff_level[8*addr+:8];
          end
        end
        `EPDB_BANK_EVENT: begin
          if (addr <= `EPDB_LAST_DATA_PORT) begin
            next_rdata = flag[8*addr+:8];
          end else if (addr == `EPDB_PORT_SUMMARY) begin
            next_rdata = {|port_any, 1'b0, port_any};
          end
        end
        `EPDB_BANK_FILTER: begin
          case (addr)
            `EPDB_PORT_FILTER_EN: next_rdata = {2'h0, filter_en};
            `EPDB_PORT_LEN_LOW: next_rdata = len_codes[7:0];
            `EPDB_PORT_LEN_HIGH: next_rdata = {4'h0, len_codes[11:8]};
            default: next_rdata = `EPDB_RST_BYTE;
          endcase
        end
        default: next_rdata = `EPDB_RST_BYTE;
      endcase
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= `EPDB_RST_BYTE;
    end else if (soft_reset) begin
      rdata <= `EPDB_RST_BYTE;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

/* File: test/epdb_field_model.sv */
// Field side model: drives the 48 field lines from levels asked by the bench.
// Assumes field inputs change just after a clock edge, as the block expects.
`default_nettype none
module epdb_field_model (
  // Clock
  input wire logic clk,
  // Requested line levels
  input wire logic [47:0] level_req,
  // Field lines
  output logic [47:0] field_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines start low, the level the pull-downs give for a floating input
  initial field_in = 48'h0000_0000_0000;
  always @(posedge clk) begin
    field_in <= level_req;
  end
endmodule
`default_nettype wire

/* File: test/epdb_top_chk.sv */
// Assertions on bank select, readback, unlock and reset of the block.
// Assumes it is bound to epdb_top and sees only its ports.
`default_nettype none
module epdb_top_chk #(
  parameter [15:0] DUR0_TICKS = 16'h0002,
  parameter [15:0] DUR1_TICKS = 16'h0003,
  parameter [15:0] DUR2_TICKS = 16'h0004,
  parameter [15:0] DUR3_TICKS = 16'h0005
) (
  // Clock and resets
  input wire logic clk,
  input wire logic reset_n,
  input wire logic soft_reset,
  // Host port
  input wire logic [2:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  // Interrupt
  input wire logic irq_enable,
  input wire logic irq_request,
  // Field lines and status
  input wire logic [47:0] field_in,
  input wire logic [47:0] line_level,
  input wire logic enhanced,
  input wire logic [1:0] bank
);
  timeunit 1ns;
  timeprecision 1ps;
  // Soft reset is left out so its own clearing is not taken for a fault
  wire logic bank_wr = enhanced && wr_en && addr == 3'h7 && !soft_reset;
  wire logic rd_ok = enhanced && rd_en && !soft_reset;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_bank_wr;
    bank_wr |=> bank == $past(wdata[7:6]);
  endproperty
  a_bank_wr: assert property (p_bank_wr) else $error("bank not taken from write");
  property p_bank_hold;
    !bank_wr && !soft_reset |=> $stable(bank);
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("bank changed unasked");
  property p_rd_bank;
    rd_ok && addr == 3'h7 |=> rdata == {$past(bank), 6'h00};
  endproperty
  a_rd_bank: assert property (p_rd_bank) else $error("bank readback wrong");
  property p_src_rd;
    rd_ok && addr == 3'h3 && bank == 2'h2 |=> rdata == 8'h00;
  endproperty
  a_src_rd: assert property (p_src_rd) else $error("clock select read not zero");
  property p_soft;
    soft_reset |=> !enhanced && bank == 2'h0 && rdata == 8'h00 && !irq_request;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset state wrong");
  property p_irq;
    !$past(irq_enable) |-> !irq_request;
  endproperty
  a_irq: assert property (p_irq) else $error("request without enable");
  property p_unlock;
    $rose(enhanced) |-> $past(wdata) == 8'h12 && $past(wdata, 2) == 8'h06
      && $past(wdata, 3) == 8'h0D && $past(wdata, 4) == 8'h07 && $past(wr_en, 4);
  endproperty
  a_unlock: assert property (p_unlock) else $error("enhanced without key");
  property p_line_std;
    $past(reset_n) && !$past(soft_reset) && !$past(enhanced) |-> line_level == $past(field_in);
  endproperty
  a_line_std: assert property (p_line_std) else $error("standard level filtered");
  c_unlock: cover property ($rose(enhanced));
  c_irq: cover property (irq_request);
  c_bank2: cover property (bank_wr && wdata[7:6] == 2'h2);
endmodule
bind epdb_top epdb_top_chk #(
  .DUR0_TICKS(DUR0_TICKS), .DUR1_TICKS(DUR1_TICKS),
  .DUR2_TICKS(DUR2_TICKS), .DUR3_TICKS(DUR3_TICKS)
) epdb_top_chk_inst (
  .clk(clk), .reset_n(reset_n), .soft_reset(soft_reset), .addr(addr), .wr_en(wr_en),
  .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .irq_enable(irq_enable),
  .irq_request(irq_request), .field_in(field_in), .line_level(line_level),
  .enhanced(enhanced), .bank(bank)
);
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for polarity, bank select and debounce.
// Assumes short debounce counts and the field line model on the far side.
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic soft_reset = 1'b0;
  logic [2:0] addr = 3'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic irq_enable = 1'b0;
  logic [47:0] lreq = 48'h0000_0000_0000;
  logic [7:0] rv;
  logic [7:0] keys [4] = '{8'h07, 8'h0D, 8'h06, 8'h12};
  wire logic [7:0] rdata;
  wire logic irq_request;
  wire logic [47:0] field_in;
  wire logic [47:0] line_level;
  wire logic enhanced;
  wire logic [1:0] bank;
  int err_total = 0;
  int n_checks = 0;
  always #4 clk = ~clk;
  // Short counts keep the run small: 2, 3, 4, 5 ticks of 15 clocks
  epdb_top #(.DUR0_TICKS(16'h0002), .DUR1_TICKS(16'h0003), .DUR2_TICKS(16'h0004),
    .DUR3_TICKS(16'h0005)) epdb_top_inst (.clk(clk), .reset_n(reset_n),
    .soft_reset(soft_reset), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
    .rdata(rdata), .irq_enable(irq_enable), .irq_request(irq_request),
    .field_in(field_in), .line_level(line_level), .enhanced(enhanced), .bank(bank));
  epdb_field_model epdb_field_model_inst (.clk(clk), .level_req(lreq), .field_in(field_in));
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    `CHK("port read", e, rdata)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task complete_run;
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    idle(20000);
    err_total++;
    complete_run;
  end
  initial begin
    idle(12);
    reset_n <= 1'b1;
    @(negedge clk);
    `CHK("enhanced", 1'b0, enhanced)
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      addr <= 3'h7;
      wdata <= keys[i];
      wr_en <= 1'b1;
      @(posedge clk);
    end
    wr_en <= 1'b0;
    idle(2);
    `CHK("enhanced", 1'b1, enhanced)
    for (int b = 0; b < 3; b++) begin
      wr(3'h7, {b[1:0], 6'h00});
      rchk(3'h7, {b[1:0], 6'h00});
      `CHK("bank", b[1:0], bank)
    end
    rchk(3'h0, 8'h00);
    rchk(3'h1, 8'h00);
    rchk(3'h2, 8'h00);
    wr(3'h0, 8'hFF);
    rchk(3'h0, 8'h3F);
    wr(3'h2, 8'hFF);
    rchk(3'h2, 8'h0F);
    wr(3'h3, 8'hFF);
    rchk(3'h3, 8'h00);
    wr(3'h1, 8'h03);
    rchk(3'h1, 8'h03);
    // A pulse shorter than the longest code must not pass the filter
    lreq[2] <= 1'b1;
    idle(10);
    lreq[2] <= 1'b0;
    idle(100);
    `CHK("glitch", 1'b0, line_level[2])
    lreq[2] <= 1'b1;
    idle(45);
    `CHK("early", 1'b0, line_level[2])
    idle(60);
    `CHK("settled", 1'b1, line_level[2])
    wr(3'h0, 8'h00);
    wr(3'h7, 8'h40);
    wr(3'h6, 8'h01);
    wr(3'h7, 8'h71);
    lreq[0] <= 1'b1;
    idle(3);
    lreq[0] <= 1'b0;
    idle(3);
    rchk(3'h0, 8'h00);
    wr(3'h0, 8'hFF);
    wr(3'h4, 8'hFF);
    lreq[0] <= 1'b1;
    lreq[4] <= 1'b1;
    idle(4);
    rchk(3'h0, 8'h01);
    lreq[4] <= 1'b0;
    idle(4);
    rchk(3'h0, 8'h11);
    lreq[32] <= 1'b1;
    lreq[36] <= 1'b1;
    idle(4);
    rchk(3'h4, 8'h01);
    `CHK("irq off", 1'b0, irq_request)
    @(posedge clk);
    irq_enable <= 1'b1;
    idle(3);
    `CHK("irq on", 1'b1, irq_request)
    irq_enable <= 1'b0;
    rchk(3'h6, 8'h91);
    wr(3'h0, 8'h00);
    rchk(3'h0, 8'h00);
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    @(negedge clk);
    `CHK("bank", 2'h0, bank)
    rchk(3'h0, 8'h05);
    complete_run;
  end
endmodule
`default_nettype wire
